// ### eag_mem_model.sv
// Purpose: Word-addressed core storage answering the generator.
// Assumes: lag sets the extra wait before each ack.
// Notes: Read data toggles whenever it is not valid.
`timescale 1ns/1ps
`default_nettype none
module eag_mem_model (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [1:0] lag,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   output logic mem_ack,
   output logic [15:0] mem_rdata
);
   logic [15:0] mem [0:65535];
   logic [1:0] wait_n;
   int n_wr = 0;
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mem_ack <= 1'b0;
         mem_rdata <= 16'h0000;
         wait_n <= 2'h0;
      end else if (mem_req && !mem_ack && wait_n >= lag) begin
         mem_ack <= 1'b1;
         wait_n <= 2'h0;
         mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr];
         if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
            n_wr <= n_wr + 1;
         end
      end else begin
         mem_ack <= 1'b0;
         wait_n <= (mem_req && !mem_ack) ? wait_n + 2'h1 : 2'h0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule
`default_nettype wire

// ### eag_ones_adder.sv
// Purpose: One's complement adder with end-around carry.
// Assumes: Both operands are one's complement numbers of the same width.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module eag_ones_adder #(
   parameter int WIDTH = 16
) (
   input wire logic [WIDTH-1:0] addend_a,
   input wire logic [WIDTH-1:0] addend_b,
   output logic [WIDTH-1:0] sum
);
   logic [WIDTH:0] raw;

   always_comb begin
      raw = {1'b0, addend_a} + {1'b0, addend_b};
      // The carry out of the top bit wraps around into bit zero.
      sum = raw[WIDTH-1:0] + {{(WIDTH-1){1'b0}}, raw[WIDTH]};
   end
endmodule
`default_nettype wire

// ### eag_pkg.sv
// Purpose: Shared constants and types for the effective address generator.
// Assumes: 16-bit words and a 4-bit operation code in the top nibble of each instruction.
// Notes: Storage word 00FF serves as the second index register.
`default_nettype none
package eag_pkg;
   localparam int EAG_WORD_W = 16;
   localparam int EAG_DELTA_W = 8;
   localparam int EAG_SIGN_BIT = 15;
   localparam int EAG_DELTA_SIGN_BIT = 7;
   localparam logic [15:0] EAG_INDEX2_ADDR = 16'h00FF;
   localparam logic [3:0] EAG_OP_STORE_AUX = 4'h4;
   localparam logic [3:0] EAG_OP_STORE_ACC = 4'h6;
   localparam logic [15:0] EAG_STEP_ONE_WORD = 16'h0001;
   localparam logic [15:0] EAG_STEP_TWO_WORDS = 16'h0002;
   localparam logic [15:0] EAG_WORD_RESET = 16'h0000;

   typedef enum logic [6:0] {
      EAG_IDLE   = 7'b0000001,
      EAG_FETCH2 = 7'b0000010,
      EAG_INDIR  = 7'b0000100,
      EAG_ADDQ   = 7'b0001000,
      EAG_INDEX2 = 7'b0010000,
      EAG_STORE  = 7'b0100000,
      EAG_FINISH = 7'b1000000
   } eag_state_type;
endpackage
`default_nettype wire

// ### eag_top.sv
// Purpose: Effective address generation and store execution for storage reference instructions.
// Assumes: Storage answers each request with a one-cycle mem_ack on sys_clk; all inputs share sys_clk.
// Notes: A start pulse in idle latches the opcode and mode fields, the program address plus one and both accumulators.
`timescale 1ns/1ps
`default_nettype none
module eag_top
   import eag_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [15:0] instruction,
   input wire logic [15:0] prog_addr,
   input wire logic [15:0] aux_accumulator,
   input wire logic [15:0] accumulator,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   output logic mem_req,
   output logic mem_we,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic busy,
   output logic done,
   output logic [15:0] eff_addr,
   output logic [15:0] next_instr_addr,
   output logic operand_is_constant
);
   eag_state_type state, next_state;
   logic [3:0] opcode, next_opcode;
   logic [3:0] mode, next_mode;
   logic [15:0] p_plus_one, next_p_plus_one;
   logic [15:0] aux_copy, next_aux_copy;
   logic [15:0] acc_copy, next_acc_copy;
   logic [15:0] running, next_running;
   logic is_constant, next_is_constant;
   logic next_mem_req, next_mem_we, next_busy, next_done, next_operand_is_constant;
   logic [15:0] next_mem_addr, next_mem_wdata, next_eff_addr, next_next_instr_addr;
   logic [15:0] add_a, add_b, add_sum;
   logic base_ready, ea_ready, ptr_ready;
   logic [15:0] base_val, ea_val, ptr_val;

   function automatic logic [15:0] sign_extend(input logic [7:0] d);
      return {{8{d[EAG_DELTA_SIGN_BIT]}}, d};
   endfunction

   function automatic logic is_store(input logic [3:0] op);
      return (op == EAG_OP_STORE_AUX) || (op == EAG_OP_STORE_ACC);
   endfunction

   eag_ones_adder #(.WIDTH(EAG_WORD_W)) u_adder (
      .addend_a(add_a),
      .addend_b(add_b),
      .sum(add_sum)
   );

   // Adder operands follow the state so that one adder serves every step.
   always_comb begin
      add_a = running;
      add_b = aux_copy;
      if (state == EAG_IDLE) begin
         add_a = prog_addr;
         add_b = sign_extend(instruction[7:0]);
      end else if (state == EAG_FETCH2) begin
         add_a = p_plus_one;
         add_b = mem_rdata;
      end else if (state == EAG_INDEX2) begin
         add_a = running;
         add_b = mem_rdata;
      end
   end

   always_comb begin
      next_state = state;
      next_opcode = opcode;
      next_mode = mode;
      next_p_plus_one = p_plus_one;
      next_aux_copy = aux_copy;
      next_acc_copy = acc_copy;
      next_running = running;
      next_is_constant = is_constant;
      next_mem_req = mem_req;
      next_mem_we = mem_we;
      next_mem_addr = mem_addr;
      next_mem_wdata = mem_wdata;
      next_busy = busy;
      next_done = 1'b0;
      next_eff_addr = eff_addr;
      next_next_instr_addr = next_instr_addr;
      next_operand_is_constant = operand_is_constant;
      base_ready = 1'b0;
      base_val = running;
      ea_ready = 1'b0;
      ea_val = running;
      ptr_ready = 1'b0;
      ptr_val = running;

      case (state)
         EAG_IDLE: begin
            if (start) begin
               next_opcode = instruction[15:12];
               next_mode = instruction[11:8];
               next_p_plus_one = prog_addr + EAG_STEP_ONE_WORD;
               next_aux_copy = aux_accumulator;
               next_acc_copy = accumulator;
               next_is_constant = 1'b0;
               next_busy = 1'b1;
               if (instruction[7:0] != 8'h00) begin
                  next_next_instr_addr = prog_addr + EAG_STEP_ONE_WORD;
                  case (instruction[11:10])
                     2'b00: begin
                        base_ready = 1'b1;
                        base_val = {8'h00, instruction[7:0]};
                     end
                     2'b01: begin
                        ptr_ready = 1'b1;
                        ptr_val = {8'h00, instruction[7:0]};
                     end
                     2'b10: begin
                        base_ready = 1'b1;
                        base_val = add_sum;
                     end
                     default: begin
                        ptr_ready = 1'b1;
                        ptr_val = add_sum;
                     end
                  endcase
               end else begin
                  next_next_instr_addr = prog_addr + EAG_STEP_TWO_WORDS;
                  if (instruction[11:8] == 4'h0) begin
                     base_ready = 1'b1;
                     base_val = prog_addr + EAG_STEP_ONE_WORD;
                  end else begin
                     next_state = EAG_FETCH2;
                     next_mem_req = 1'b1;
                     next_mem_we = 1'b0;
                     next_mem_addr = prog_addr + EAG_STEP_ONE_WORD;
                  end
               end
            end
         end
         EAG_FETCH2: begin
            if (mem_ack) begin
               next_mem_req = 1'b0;
               case (mode[3:2])
                  2'b00: begin
                     base_ready = 1'b1;
                     base_val = mem_rdata;
                     next_is_constant = 1'b1;
                  end
                  2'b01: begin
                     if (mem_rdata[EAG_SIGN_BIT]) begin
                        ptr_ready = 1'b1;
                        ptr_val = {1'b0, mem_rdata[14:0]};
                     end else begin
                        base_ready = 1'b1;
                        base_val = mem_rdata;
                     end
                  end
                  2'b10: begin
                     base_ready = 1'b1;
                     base_val = add_sum;
                  end
                  default: begin
                     ptr_ready = 1'b1;
                     ptr_val = add_sum;
                  end
               endcase
            end
         end
         EAG_INDIR: begin
            if (mem_ack) begin
               next_mem_req = 1'b0;
               if (mem_rdata[EAG_SIGN_BIT]) begin
                  ptr_ready = 1'b1;
                  ptr_val = {1'b0, mem_rdata[14:0]};
               end else begin
                  base_ready = 1'b1;
                  base_val = mem_rdata;
               end
            end
         end
         EAG_ADDQ: begin
            next_running = add_sum;
            if (mode[0]) begin
               next_state = EAG_INDEX2;
               next_mem_req = 1'b1;
               next_mem_we = 1'b0;
               next_mem_addr = EAG_INDEX2_ADDR;
            end else begin
               ea_ready = 1'b1;
               ea_val = add_sum;
            end
         end
         EAG_INDEX2: begin
            if (mem_ack) begin
               next_mem_req = 1'b0;
               ea_ready = 1'b1;
               ea_val = add_sum;
            end
         end
         EAG_STORE: begin
            if (mem_ack) begin
               next_mem_req = 1'b0;
               next_mem_we = 1'b0;
               next_state = EAG_FINISH;
            end
         end
         EAG_FINISH: begin
            next_state = EAG_IDLE;
            next_busy = 1'b0;
            next_done = 1'b1;
         end
         default: begin
            next_state = EAG_IDLE;
            next_busy = 1'b0;
            next_mem_req = 1'b0;
            next_mem_we = 1'b0;
         end
      endcase

      if (ptr_ready) begin
         next_state = EAG_INDIR;
         next_mem_req = 1'b1;
         next_mem_we = 1'b0;
         next_mem_addr = ptr_val;
      end

      // Indexing starts only once the base address is final.
      if (base_ready) begin
         next_running = base_val;
         if (next_mode[1]) begin
            next_state = EAG_ADDQ;
         end else if (next_mode[0]) begin
            next_state = EAG_INDEX2;
            next_mem_req = 1'b1;
            next_mem_we = 1'b0;
            next_mem_addr = EAG_INDEX2_ADDR;
         end else begin
            ea_ready = 1'b1;
            ea_val = base_val;
         end
      end

      if (ea_ready) begin
         next_eff_addr = ea_val;
         next_operand_is_constant = next_is_constant;
         if (next_opcode == EAG_OP_STORE_AUX) begin
            next_state = EAG_STORE;
            next_mem_req = 1'b1;
            next_mem_we = 1'b1;
            next_mem_addr = ea_val;
            next_mem_wdata = next_aux_copy;
         end else if (next_opcode == EAG_OP_STORE_ACC) begin
            next_state = EAG_STORE;
            next_mem_req = 1'b1;
            next_mem_we = 1'b1;
            next_mem_addr = ea_val;
            next_mem_wdata = next_acc_copy;
         end else begin
            next_state = EAG_FINISH;
         end
         if (is_store(next_opcode)) begin
            next_operand_is_constant = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= EAG_IDLE;
         opcode <= 4'h0;
         mode <= 4'h0;
         p_plus_one <= EAG_WORD_RESET;
         aux_copy <= EAG_WORD_RESET;
         acc_copy <= EAG_WORD_RESET;
         running <= EAG_WORD_RESET;
         is_constant <= 1'b0;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= EAG_WORD_RESET;
         mem_wdata <= EAG_WORD_RESET;
         busy <= 1'b0;
         done <= 1'b0;
         eff_addr <= EAG_WORD_RESET;
         next_instr_addr <= EAG_WORD_RESET;
         operand_is_constant <= 1'b0;
      end else begin
         state <= next_state;
         opcode <= next_opcode;
         mode <= next_mode;
         p_plus_one <= next_p_plus_one;
         aux_copy <= next_aux_copy;
         acc_copy <= next_acc_copy;
         running <= next_running;
         is_constant <= next_is_constant;
         mem_req <= next_mem_req;
         mem_we <= next_mem_we;
         mem_addr <= next_mem_addr;
         mem_wdata <= next_mem_wdata;
         busy <= next_busy;
         done <= next_done;
         eff_addr <= next_eff_addr;
         next_instr_addr <= next_next_instr_addr;
         operand_is_constant <= next_operand_is_constant;
      end
   end
endmodule
`default_nettype wire

// ### eag_top_props.sv
// Purpose: Port checker for eag_top.
// Assumes: Storage acks each request with a one-cycle pulse.
// Notes: The accepted command is latched at start.
`timescale 1ns/1ps
`default_nettype none
module eag_top_props
   import eag_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic start,
   input wire logic [15:0] instruction,
   input wire logic [15:0] prog_addr,
   input wire logic [15:0] aux_accumulator,
   input wire logic [15:0] accumulator,
   input wire logic mem_ack,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic busy,
   input wire logic done,
   input wire logic [15:0] eff_addr,
   input wire logic [15:0] next_instr_addr,
   input wire logic operand_is_constant
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic [15:0] cmd, q_l, a_l, w_addr;
   logic saw_ff;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cmd <= 16'h0000;
         q_l <= 16'h0000;
         a_l <= 16'h0000;
         w_addr <= 16'h0000;
         saw_ff <= 1'b0;
      end else if (start && !busy) begin
         cmd <= instruction;
         q_l <= aux_accumulator;
         a_l <= accumulator;
         saw_ff <= 1'b0;
      end else if (mem_req && mem_ack) begin
         if (mem_we) w_addr <= mem_addr;
         if (!mem_we && mem_addr == EAG_INDEX2_ADDR) saw_ff <= 1'b1;
      end
   end
   sequence s_go;
      start && !busy;
   endsequence
   sequence s_wr;
      mem_req && mem_we;
   endsequence
   a_next_one: assert property (s_go ##0 instruction[7:0] != 8'h00 |=>
      next_instr_addr == $past(prog_addr) + 16'h0001) else $error("next address not P+1");
   a_next_two: assert property (s_go ##0 instruction[7:0] == 8'h00 |=>
      next_instr_addr == $past(prog_addr) + 16'h0002) else $error("next address not P+2");
   a_busy_go: assert property (s_go |=> busy) else $error("busy not raised");
   a_aux_data: assert property (s_wr ##0 cmd[15:12] == EAG_OP_STORE_AUX |-> mem_wdata == q_l)
      else $error("store data not Q");
   a_acc_data: assert property (s_wr ##0 cmd[15:12] == EAG_OP_STORE_ACC |-> mem_wdata == a_l)
      else $error("store data not A");
   a_write_only_store: assert property (s_wr |-> cmd[15:12] inside {4'h4, 4'h6})
      else $error("write on a non-store");
   a_write_at_ea: assert property (done && cmd[15:12] inside {4'h4, 4'h6} |-> eff_addr == w_addr)
      else $error("write not at effective address");
   a_const_flag: assert property (done |-> operand_is_constant == (cmd[11:10] == 2'b00
      && cmd[7:0] == 8'h00 && cmd[9:8] != 2'b00 && !(cmd[15:12] inside {4'h4, 4'h6})))
      else $error("constant flag wrong");
   a_abs_base: assert property (done && cmd[11:8] == 4'h0 && cmd[7:0] != 8'h00
      |-> eff_addr == {8'h00, cmd[7:0]}) else $error("absolute address wrong");
   a_index_two: assert property (done && cmd[8] |-> saw_ff) else $error("00FF not read");
   a_req_holds: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
      && $stable(mem_we) && $stable(mem_wdata)) else $error("request dropped early");
   a_done_pulse: assert property (done |-> !busy ##1 !done) else $error("done not a pulse");
endmodule
bind eag_top eag_top_props eag_top_props_i(.*);
`default_nettype wire

// ### testbench.sv
// Purpose: Self-checking bench for eag_top.
// Assumes: Storage words keep bit 15 clear unless a corner case plants a chain link or a negative value.
// Notes: Expected results come from a reference model of the addressing modes.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import eag_pkg::*;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic start = 1'b0;
   logic [1:0] lag = 2'h0;
   logic [15:0] instruction = 16'h0000, prog_addr = 16'h0000, aux_accumulator = 16'h0000, accumulator = 16'h0000;
   logic mem_ack, mem_req, mem_we, busy, done, operand_is_constant;
   logic [15:0] mem_rdata, mem_addr, mem_wdata, eff_addr, next_instr_addr;
   logic [31:0] seed = 32'h59212B72;
   logic [31:0] r;
   int n_fail = 0, compares = 0, cyc = 0, i, wr0;
   always #2.5 sys_clk = ~sys_clk;
   eag_top eag_top_i(.*);
   eag_mem_model eag_mem_model_i(.*);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] oc(input logic [15:0] x, input logic [15:0] y);
      logic [16:0] s;
      s = {1'b0, x} + {1'b0, y};
      return s[15:0] + {15'h0000, s[16]};
   endfunction
   function automatic logic [15:0] rd(input logic [15:0] x);
      return eag_mem_model_i.mem[x];
   endfunction
   function automatic logic [15:0] ea(input logic [15:0] c, input logic [15:0] p, input logic [15:0] q);
      logic [15:0] p1, w, b;
      p1 = p + 16'h0001;
      w = rd(p1);
      if (c[7:0] != 8'h00) b = c[11] ? oc(p, {{8{c[7]}}, c[7:0]}) : {8'h00, c[7:0]};
      else b = c[11] ? oc(p1, w) : w;
      if (c[10]) begin
         b = (c[7:0] == 8'h00 && !c[11]) ? w : rd(b);
         while (b[15]) b = rd({1'b0, b[14:0]});
      end
      if (c[11:0] == 12'h000) return p1;
      if (c[9]) b = oc(b, q);
      if (c[8]) b = oc(b, rd(EAG_INDEX2_ADDR));
      return b;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic run(input logic [15:0] c, input logic [15:0] p, input logic [15:0] q);
      logic [15:0] e, a;
      logic st, cst;
      int k;
      e = ea(c, p, q);
      a = 16'(rnd()) & 16'h7FFF;
      st = c[15:12] == EAG_OP_STORE_AUX || c[15:12] == EAG_OP_STORE_ACC;
      cst = c[11:10] == 2'b00 && c[7:0] == 8'h00 && c[9:8] != 2'b00 && !st;
      wr0 = eag_mem_model_i.n_wr;
      @(posedge sys_clk);
      start <= 1'b1;
      instruction <= c;
      prog_addr <= p;
      aux_accumulator <= q;
      accumulator <= a;
      lag <= 2'(rnd());
      @(posedge sys_clk);
      start <= 1'b0;
      k = 0;
      do @(negedge sys_clk); while (done !== 1'b1 && ++k < 400);
      check({15'h0000, done}, 16'h0001);
      check(eff_addr, e);
      check(next_instr_addr, p + ((c[7:0] == 8'h00) ? 16'h0002 : 16'h0001));
      check({15'h0000, operand_is_constant}, {15'h0000, cst});
      check(16'(eag_mem_model_i.n_wr - wr0), st ? 16'h0001 : 16'h0000);
      if (st) check(rd(e), c[13] ? a : q);
   endtask
   task automatic corner(input logic [15:0] c, p, q, a1, v1, a2, v2);
      eag_mem_model_i.mem[a1] = v1;
      eag_mem_model_i.mem[a2] = v2;
      run(c, p, q);
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   initial begin
      for (i = 0; i < 65536; i++) eag_mem_model_i.mem[i] = 16'(rnd()) & 16'h7FFF;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      corner(16'hC883, 16'h0100, 16'h0003, 16'h0084, 16'h1234, 16'h0000, 16'h0000);
      corner(16'hC800, 16'h010E, 16'h0003, 16'h010F, 16'h0011, 16'h0120, 16'h1234);
      corner(16'hCCAB, 16'h0100, 16'h0003, 16'h00AC, 16'h8102, 16'h0102, 16'h00AC);
      corner(16'hCC00, 16'h0100, 16'h0003, 16'h0101, 16'hFFFE, 16'h0100, 16'hCC00);
      corner(16'hC200, 16'h0300, 16'h0001, 16'h0301, 16'h03E8, 16'h0000, 16'h0000);
      corner(16'hC4FE, 16'h0400, 16'h0003, 16'h00FE, 16'h8500, 16'h0500, 16'h1234);
      corner(16'hC400, 16'h0600, 16'h0003, 16'h0601, 16'h8500, 16'h0500, 16'h1234);
      corner(16'hC310, 16'h0700, 16'hFFFE, 16'h00FF, 16'h0005, 16'h0000, 16'h0000);
      corner(16'h4005, 16'h0800, 16'h2BCD, 16'h0005, 16'h0000, 16'h0000, 16'h0000);
      corner(16'h6200, 16'h0900, 16'h0004, 16'h0901, 16'h0040, 16'h0000, 16'h0000);
      corner(16'hC000, 16'h0A00, 16'h0003, 16'h0A01, 16'h7777, 16'h0000, 16'h0000);
      corner(16'hCF00, 16'h0200, 16'h0002, 16'h0201, 16'h7FFE, 16'h00FF, 16'hFFFD);
      // A reset in mid-instruction abandons it and clears every output at once.
      @(posedge sys_clk);
      start <= 1'b1;
      instruction <= 16'h4F00;
      prog_addr <= 16'h0200;
      @(posedge sys_clk);
      start <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b1;
      @(negedge sys_clk);
      check({busy, mem_req, mem_we, done, operand_is_constant, 11'h000}, 16'h0000);
      check(next_instr_addr | eff_addr | mem_addr, 16'h0000);
      @(posedge sys_clk);
      reset <= 1'b0;
      @(negedge sys_clk);
      check({busy, mem_req, done, 13'h0000}, 16'h0000);
      for (i = 0; i < 256; i++) begin
         r = rnd();
         run({r[15:12], i[3:0], i[4] ? 8'h00 : r[23:16]}, r[31:16] ^ 16'(i), 16'(rnd()) & 16'h7FFF);
      end
      final_report();
   end
endmodule
`default_nettype wire
